// *** src/gst_map.svh ***
// Register offsets, field positions, reset values for the gated 16-bit timer.
// Assumes byte addresses on a 32-bit Avalon-MM slave; included by bare name.
`ifndef GST_MAP_SVH
`define GST_MAP_SVH
// ****************************************
// Register offsets (register index, byte address is four times it)
// ****************************************
`define GST_IDX_INTCTL 8'h0b
`define GST_IDX_FLAGS 8'h0c
`define GST_IDX_CNT_LO 8'h0e
`define GST_IDX_CNT_HI 8'h0f
`define GST_IDX_CTRL 8'h10
`define GST_IDX_CMP2B 8'h1a
`define GST_IDX_ENABLES 8'h8c
`define GST_IDX_SYSCFG 8'h40
`define GST_IDX_PORTA 8'h41
// ****************************************
// Field positions and reset values
// ****************************************
`define GST_CTRL_ON 0
`define GST_CTRL_CS 1
`define GST_CTRL_NOSYNC 2
`define GST_CTRL_OSCEN 3
`define GST_CTRL_PS_LO 4
`define GST_CTRL_GE 6
`define GST_CTRL_GINV 7
`define GST_INT_PERIPHERAL_INTERRUPT_ENABLE 6
`define GST_INT_GIE 7
`define GST_FLAG_OVF 0
`define GST_CMP2B_GSS 1
`define GST_CMP2B_RESET 8'h02
`define GST_DIR_RESET 8'h3f
`endif

// *** src/gst_pkg.sv ***
// Types shared by the gated 16-bit timer.
// Assumes the map header supplies all numbers.
package gst_pkg;
  typedef enum logic [1:0] {
    GST_EDGE_WAIT_LOW = 2'b00,
    GST_EDGE_ARMED = 2'b01
  } gst_edge_e;
  typedef logic [7:0] gst_byte_t;
endpackage : gst_pkg

// *** src/gst_timer.sv ***
// Gated 16-bit timer with prescaler, gate select and overflow interrupt.
// Assumes a 100 MHz sys_clk, pins asynchronous to it, Avalon-MM master.
// Notes on behaviour
// - Counter wraps all-ones to zero, sets flag.
// - Interrupt needs overflow, peripheral, global enables.
// - Flag stays set until software clears it.
// - Prescale field selects divide by 1,2,4,8.
// - Writing either counter byte clears prescaler.
// - Gate from pin or comparator two output.
// - Gate enable ignored while timer is off.
// - Invert bit picks gate true level.
// - Source select picks pin edges or internal.
// - Sync bit only decides whether sleep stops pin counting.
// - Falling edge needed before first counting edge.
// - Unsynchronised counting continues in sleep, wakes.
// - Byte reads give valid value while running.
// - Crystal enable honoured only with suitable clock.
// - Oscillator forces port A direction bits.
// - Shared low-power oscillator keeps running in sleep.
// - Wake branches to vector only if global enabled.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
`include "gst_map.svh"
module gst_timer
  import gst_pkg::*;
#(
  parameter int INSTR_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic external_clock_pin,
  input wire logic gate_input_pin,
  input wire logic comparator_two_output,
  input wire logic sleep_mode,
  output logic irq_request,
  output logic wake_request,
  output logic wake_to_vector,
  output logic lp_osc_for_timer,
  output logic keep_sys_clock_in_sleep,
  output logic [7:0] port_a_direction
);
  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] ctrl_q, intctl_q, enables_q, cmp2b_q, syscfg_q, dir_q;
  logic ovf_flag_q;
  logic [15:0] count_q;
  logic [2:0] pre_q;
  logic ack_q;
  logic [7:0] idx;
  logic wr_go, hit;
  logic [7:0] rd_byte;
  logic [2:0] icnt_q;
  assign idx = avs_address[9:2];
  // One wait state: the answer comes at the second edge of the request.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go = avs_write & ack_q & avs_byteenable[0];

  // Wait-state toggle, cleared once the request is answered.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Software-written control registers.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 8'h00;
      intctl_q <= 8'h00;
      enables_q <= 8'h00;
      cmp2b_q <= `GST_CMP2B_RESET;
      syscfg_q <= 8'h00;
      dir_q <= `GST_DIR_RESET;
    end else if (wr_go) begin
      case (idx)
        `GST_IDX_CTRL: ctrl_q <= avs_writedata[7:0];
        `GST_IDX_INTCTL: intctl_q <= avs_writedata[7:0];
        `GST_IDX_ENABLES: enables_q <= avs_writedata[7:0];
        `GST_IDX_CMP2B: cmp2b_q <= avs_writedata[7:0];
        `GST_IDX_SYSCFG: syscfg_q <= avs_writedata[7:0];
        `GST_IDX_PORTA: dir_q <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Clock source and gate
  // ****************************************
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic gate_s1_q, gate_s2_q, cmp_s1_q, cmp_s2_q;
  // First stages feed only second stages, so metastability stays contained.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      gate_s1_q <= 1'b0;
      gate_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= external_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      gate_s1_q <= gate_input_pin;
      gate_s2_q <= gate_s1_q;
      cmp_s1_q <= comparator_two_output;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Instruction clock tick, one in every INSTR_DIV system cycles.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      icnt_q <= 3'd0;
    end else if (icnt_q == 3'(INSTR_DIV - 1)) begin
      icnt_q <= 3'd0;
    end else begin
      icnt_q <= icnt_q + 3'd1;
    end
  end

  logic ext_mode, gate_raw, gate_true, run;
  logic sync_rise, sync_fall, osc_ok;
  assign ext_mode = ctrl_q[`GST_CTRL_CS];
  assign gate_raw = cmp2b_q[`GST_CMP2B_GSS] ? cmp_s2_q : gate_s2_q;
  assign gate_true = ctrl_q[`GST_CTRL_GINV] ? gate_raw : ~gate_raw;
  // Gate enable only matters while the timer is on.
  assign run = ctrl_q[`GST_CTRL_ON] & (~ctrl_q[`GST_CTRL_GE] | gate_true);
  assign sync_rise = ext_s2_q & ~ext_s3_q;
  assign sync_fall = ~ext_s2_q & ext_s3_q;
  // Crystal is usable only with the low-power or internal-no-output clock.
  assign osc_ok = syscfg_q[0] | syscfg_q[1];
  assign lp_osc_for_timer = ctrl_q[`GST_CTRL_OSCEN] & osc_ok;
  assign keep_sys_clock_in_sleep = lp_osc_for_timer & syscfg_q[0];
  assign port_a_direction = lp_osc_for_timer ? (dir_q | 8'h30) : dir_q;

  // Edge qualifier: a falling edge must be seen before counting rises.
  gst_edge_e edge_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_q <= GST_EDGE_WAIT_LOW;
    end else if (!ext_mode || !ctrl_q[`GST_CTRL_ON]) begin
      edge_q <= GST_EDGE_WAIT_LOW;
    end else if (sync_fall) begin
      edge_q <= GST_EDGE_ARMED;
    end
  end

  // The unsynchronised setting counts the same synchronised edges in this
  // single-clock build; it differs only in that sleep does not stop it.
  logic in_tick;
  always_comb begin
    if (ext_mode) begin
      in_tick = sync_rise & (edge_q == GST_EDGE_ARMED);
    end else begin
      in_tick = (icnt_q == 3'd0) & ~sleep_mode;
    end
  end

  // ****************************************
  // Prescaler and counter
  // ****************************************
  logic cnt_wr, pre_tick, ovf_evt;
  logic [2:0] pre_max;
  assign cnt_wr = wr_go & ((idx == `GST_IDX_CNT_LO) | (idx == `GST_IDX_CNT_HI));
  assign pre_max = 3'((1 << ctrl_q[`GST_CTRL_PS_LO +: 2]) - 1);
  assign pre_tick = run & in_tick & (pre_q == pre_max);
  assign ovf_evt = pre_tick & (count_q == 16'hffff);
  // Sleep halts synchronised counting; unsynchronised keeps going.
  logic sleep_block;
  assign sleep_block = sleep_mode & ~(ext_mode & ctrl_q[`GST_CTRL_NOSYNC]);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 3'd0;
    end else if (cnt_wr) begin
      pre_q <= 3'd0;
    end else if (pre_q > pre_max) begin
      pre_q <= 3'd0; // A ratio written below the current prescaler count restarts the divider.
    end else if (run & in_tick & ~sleep_block) begin
      pre_q <= (pre_q == pre_max) ? 3'd0 : pre_q + 3'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 16'h0000;
    end else if (wr_go && idx == `GST_IDX_CNT_LO) begin
      count_q[7:0] <= avs_writedata[7:0];
    end else if (wr_go && idx == `GST_IDX_CNT_HI) begin
      count_q[15:8] <= avs_writedata[7:0];
    end else if (pre_tick & ~sleep_block) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Overflow flag: hardware set wins over a software clear.
  logic flag_wr;
  assign flag_wr = wr_go & (idx == `GST_IDX_FLAGS);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_evt & ~sleep_block) begin
      ovf_flag_q <= 1'b1;
    end else if (flag_wr) begin
      ovf_flag_q <= avs_writedata[`GST_FLAG_OVF];
    end
  end

  logic pend;
  assign pend = ovf_flag_q & enables_q[0] & intctl_q[`GST_INT_PERIPHERAL_INTERRUPT_ENABLE];
  assign irq_request = pend & intctl_q[`GST_INT_GIE];
  assign wake_request = pend & sleep_mode & ctrl_q[`GST_CTRL_ON];
  assign wake_to_vector = wake_request & intctl_q[`GST_INT_GIE];

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    hit = 1'b1;
    case (idx)
      `GST_IDX_INTCTL: rd_byte = intctl_q;
      `GST_IDX_FLAGS: rd_byte = {7'd0, ovf_flag_q};
      `GST_IDX_CNT_LO: rd_byte = count_q[7:0];
      `GST_IDX_CNT_HI: rd_byte = count_q[15:8];
      `GST_IDX_CTRL: rd_byte = ctrl_q;
      `GST_IDX_CMP2B: rd_byte = cmp2b_q;
      `GST_IDX_ENABLES: rd_byte = enables_q;
      `GST_IDX_SYSCFG: rd_byte = syscfg_q;
      `GST_IDX_PORTA: rd_byte = port_a_direction;
      default: begin
        rd_byte = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // Read data registered in the answering cycle; unmapped reads give zero.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
      if ((avs_read | avs_write) & ~ack_q) begin
        avs_readdata <= {24'h00_0000, rd_byte};
        avs_response <= hit ? 2'b00 : 2'b10;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_ovf_sets;
    @(posedge sys_clk) disable iff (!arst_n) (ovf_evt & ~sleep_block & ~cnt_wr) |=> ovf_flag_q && count_q == 16'h0000;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow did not set flag");
  property p_irq;
    @(posedge sys_clk) disable iff (!arst_n) irq_request |-> ovf_flag_q && enables_q[0] && intctl_q[7:6] == 2'b11;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enables");
  property p_flag_hold;
    @(posedge sys_clk) disable iff (!arst_n) (ovf_flag_q && !flag_wr) |=> ovf_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");
  property p_pre_clr;
    @(posedge sys_clk) disable iff (!arst_n) cnt_wr |=> pre_q == 3'd0;
  endproperty
  a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");
  property p_off_hold;
    @(posedge sys_clk) disable iff (!arst_n) (!ctrl_q[0] && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counted while off");
  property p_pre_lim;
    @(posedge sys_clk) disable iff (!arst_n) pre_q <= pre_max || $changed(ctrl_q);
  endproperty
  a_pre_lim: assert property (p_pre_lim) else $error("prescaler out of range");
  property p_gate;
    @(posedge sys_clk) disable iff (!arst_n) (ctrl_q[6] && !gate_true && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_gate: assert property (p_gate) else $error("counted with gate false");
  property p_dir;
    @(posedge sys_clk) disable iff (!arst_n) lp_osc_for_timer |-> port_a_direction[5:4] == 2'b11;
  endproperty
  a_dir: assert property (p_dir) else $error("direction bits not forced");

  // ****************************************
  // Further checks on counting, wake-up and the bus answer
  // ****************************************
  // Every qualified prescaler tick adds exactly one, wrapping at the top.
  property p_cnt_inc;
    @(posedge sys_clk) disable iff (!arst_n)
      (pre_tick & ~sleep_block & ~cnt_wr) |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step by one");
  // With all three enables set, a pending flag must reach the request line.
  property p_irq_on;
    @(posedge sys_clk) disable iff (!arst_n)
      (ovf_flag_q && enables_q[0] && intctl_q[`GST_INT_GIE] && intctl_q[`GST_INT_PERIPHERAL_INTERRUPT_ENABLE]) |-> irq_request;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled interrupt not raised");
  // A flag write without a same-cycle overflow stores the written bit.
  property p_flag_clr;
    @(posedge sys_clk) disable iff (!arst_n)
      (flag_wr && !(ovf_evt && !sleep_block)) |=> ovf_flag_q == $past(avs_writedata[`GST_FLAG_OVF]);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag write not applied");
  // Prescaler ticks short of the selected ratio leave the count alone.
  property p_pre_step;
    @(posedge sys_clk) disable iff (!arst_n)
      (run && in_tick && pre_q < pre_max && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("count moved before prescale end");
  // The internal source counts only on instruction clock ticks.
  property p_int_tick;
    @(posedge sys_clk) disable iff (!arst_n)
      (!ext_mode && icnt_q != 3'h0 && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_int_tick: assert property (p_int_tick) else $error("count moved between instruction ticks");
  // No external edge counts until a falling edge has armed the qualifier.
  property p_ext_arm;
    @(posedge sys_clk) disable iff (!arst_n)
      (ext_mode && edge_q == GST_EDGE_WAIT_LOW) |-> !in_tick;
  endproperty
  a_ext_arm: assert property (p_ext_arm) else $error("rising edge counted before falling edge");
  // Sleep freezes every source except the unsynchronised pin.
  property p_sleep_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (sleep_block && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");
  // Wake-up needs sleep, a running timer, the flag and both lower enables.
  property p_wake;
    @(posedge sys_clk) disable iff (!arst_n)
      wake_request |-> (sleep_mode && ctrl_q[`GST_CTRL_ON] && ovf_flag_q && enables_q[0] && intctl_q[`GST_INT_PERIPHERAL_INTERRUPT_ENABLE]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without its conditions");
  // The system clock is held in sleep only when it shares the crystal.
  property p_keep;
    @(posedge sys_clk) disable iff (!arst_n)
      keep_sys_clock_in_sleep |-> (lp_osc_for_timer && syscfg_q[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("clock kept without shared crystal");
  // The vectored wake-up also needs the global enable.
  property p_vector;
    @(posedge sys_clk) disable iff (!arst_n)
      wake_to_vector |-> (wake_request && intctl_q[`GST_INT_GIE]);
  endproperty
  a_vector: assert property (p_vector) else $error("vector without global enable");
  // A request never waits more than one cycle for its answer.
  property p_bus_ans;
    @(posedge sys_clk) disable iff (!arst_n)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
  // A write to the low byte lands in the count unchanged.
  property p_lo_write;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_go && idx == `GST_IDX_CNT_LO) |=> count_q[7:0] == $past(avs_writedata[7:0]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low byte write lost");
endmodule : gst_timer

// *** dv/gst_pin_model.sv ***
// Far-side model of the timer's external counting clock pin.
// Assumes one sys_clk domain; the pin resets high and stands still while run is low.
`timescale 1ns/100ps
module gst_pin_model
  import gst_pkg::*;
#(
  parameter int HALF = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic run,
  output logic external_clock_pin
);
  // ****************************************
  // Clock pin generator
  // ****************************************
  logic [7:0] cnt_q;
  // Toggle every HALF cycles while running. Holding still between bursts keeps edge counts predictable.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 8'h00;
      external_clock_pin <= 1'b1;
    end else if (run) begin
      if (cnt_q == 8'(HALF - 1)) begin
        cnt_q <= 8'h00;
        external_clock_pin <= ~external_clock_pin;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : gst_pin_model

// *** dv/gst_timer_tb.sv ***
// Self-checking bench for the gated 16-bit timer, driven over Avalon-MM.
// Assumes the map header and package compile first; pins are driven from this bench.
`timescale 1ns/100ps
`include "gst_map.svh"
module gst_timer_tb
  import gst_pkg::*;
;
  // ****************************************
  // Harness
  // ****************************************
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic gate_input_pin = 1'b0;
  logic comparator_two_output = 1'b0;
  logic sleep_mode = 1'b0;
  logic run = 1'b0;
  logic external_clock_pin;
  logic irq_request, wake_request, wake_to_vector, lp_osc_for_timer, keep_sys_clock_in_sleep;
  logic [7:0] port_a_direction;
  logic [7:0] rdv, cnt;
  logic [1:0] rsp;
  logic [3:0] nz;
  int fail_count = 0;
  int tests_run = 0;
  int exp_i;
  localparam logic [7:0] RI [8] = '{`GST_IDX_INTCTL, `GST_IDX_FLAGS, `GST_IDX_CTRL, `GST_IDX_CMP2B,
    `GST_IDX_ENABLES, `GST_IDX_PORTA, `GST_IDX_CNT_LO, `GST_IDX_CNT_HI};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h3f, 8'h00, 8'h00};
  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;
  gst_timer gst_timer_inst (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .external_clock_pin,
    .gate_input_pin, .comparator_two_output, .sleep_mode, .irq_request, .wake_request,
    .wake_to_vector, .lp_osc_for_timer, .keep_sys_clock_in_sleep, .port_a_direction);
  gst_pin_model gst_pin_model_inst (.sys_clk, .arst_n, .run, .external_clock_pin);
  // ****************************************
  // Tasks
  // ****************************************
  // Verdict and end of run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Compare seen against expected; four-state equality, so an unknown bit matches only an unknown expected bit.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One bus transfer held until waitrequest is sampled low; the wait is bounded.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdv = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("ERROR %0t bus timeout", $time);
      finish_test();
    end
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    chk(32'(rdv), 32'(exp));
  endtask : rd
  // Clear the count, run with ctrl for cyc cycles, stop, and read the low byte.
  task automatic run_cnt(input logic [7:0] ctrl, input int cyc, input logic ext, output logic [7:0] c);
    wr(`GST_IDX_CNT_LO, 8'h00);
    wr(`GST_IDX_CNT_HI, 8'h00);
    wr(`GST_IDX_CTRL, ctrl);
    run <= ext;
    repeat (cyc) @(posedge sys_clk);
    run <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(`GST_IDX_CTRL, 8'h00);
    bus(1'b0, `GST_IDX_CNT_LO, 8'h00, 4'hf);
    c = rdv;
  endtask : run_cnt
  // ****************************************
  // Test sequence
  // ****************************************
  // Reset, then one scenario per behaviour; a stuck bus ends the run through finish_test.
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(RI[i], RV[i]);
    end
    chk(32'(port_a_direction), 32'h0000_003f);
    bus(1'b0, 8'h20, 8'h00, 4'hf);
    chk(32'(rsp), 32'h0000_0002);
    bus(1'b1, `GST_IDX_ENABLES, 8'h01, 4'h0);
    rd(`GST_IDX_ENABLES, 8'h00);
    for (int ps = 0; ps < 4; ps++) begin
      run_cnt(8'(1 | (ps << 4)), 400, 1'b0, cnt);
      exp_i = 408 / (4 << ps);
      chk(32'(int'(cnt) >= exp_i - 3 && int'(cnt) <= exp_i + 2), 32'h0000_0001);
      rd(`GST_IDX_CNT_LO, cnt);
    end
    comparator_two_output <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      wr(`GST_IDX_CMP2B, g[1] ? 8'h02 : 8'h00);
      run_cnt(8'(8'h41 | (g[0] << 7)), 100, 1'b0, cnt);
      nz[g] = (cnt != 8'h00);
    end
    chk(32'(nz), 32'h0000_0009);
    run_cnt(8'h01, 100, 1'b0, cnt);
    chk(32'(cnt != 8'h00), 32'h0000_0001);
    run_cnt(8'h40, 100, 1'b0, cnt);
    chk(32'(cnt), 32'h0000_0000);
    // Odd toggle counts leave the pin low, so the last burst opens with a rising edge.
    run_cnt(8'h03, 168, 1'b1, cnt);
    chk(32'(cnt), 32'h0000_000a);
    sleep_mode <= 1'b1;
    run_cnt(8'h03, 160, 1'b1, cnt);
    chk(32'(cnt), 32'h0000_0000);
    run_cnt(8'h07, 168, 1'b1, cnt);
    chk(32'(cnt), 32'h0000_000a);
    sleep_mode <= 1'b0;
    wr(`GST_IDX_FLAGS, 8'h00);
    wr(`GST_IDX_ENABLES, 8'h01);
    wr(`GST_IDX_INTCTL, 8'h40);
    wr(`GST_IDX_CNT_LO, 8'hfe);
    wr(`GST_IDX_CNT_HI, 8'hff);
    wr(`GST_IDX_CTRL, 8'h01);
    repeat (40) @(posedge sys_clk);
    rd(`GST_IDX_FLAGS, 8'h01);
    rd(`GST_IDX_CNT_HI, 8'h00);
    chk(32'(irq_request), 32'h0000_0000);
    sleep_mode <= 1'b1;
    @(posedge sys_clk);
    chk(32'(wake_request), 32'h0000_0001);
    chk(32'(wake_to_vector), 32'h0000_0000);
    wr(`GST_IDX_INTCTL, 8'hc0);
    @(posedge sys_clk);
    chk(32'(irq_request), 32'h0000_0001);
    chk(32'(wake_to_vector), 32'h0000_0001);
    sleep_mode <= 1'b0;
    repeat (50) @(posedge sys_clk);
    rd(`GST_IDX_FLAGS, 8'h01);
    wr(`GST_IDX_FLAGS, 8'h00);
    wr(`GST_IDX_CTRL, 8'h00);
    @(posedge sys_clk);
    chk(32'(irq_request), 32'h0000_0000);
    wr(`GST_IDX_PORTA, 8'h00);
    wr(`GST_IDX_SYSCFG, 8'h01);
    wr(`GST_IDX_CTRL, 8'h08);
    @(posedge sys_clk);
    chk(32'(lp_osc_for_timer), 32'h0000_0001);
    chk(32'(keep_sys_clock_in_sleep), 32'h0000_0001);
    chk(32'(port_a_direction), 32'h0000_0030);
    rd(`GST_IDX_PORTA, 8'h30);
    wr(`GST_IDX_SYSCFG, 8'h02);
    @(posedge sys_clk);
    chk(32'(keep_sys_clock_in_sleep), 32'h0000_0000);
    wr(`GST_IDX_SYSCFG, 8'h00);
    @(posedge sys_clk);
    chk(32'(lp_osc_for_timer), 32'h0000_0000);
    chk(32'(port_a_direction), 32'h0000_0000);
    finish_test();
  end
endmodule : gst_timer_tb
